// ==== hdl/aclp_map.svh ====
// constants for the axis command line parser
`ifndef ACLP_MAP_SVH
`define ACLP_MAP_SVH

`define ACLP_BUF_DEPTH   6'h20
`define ACLP_CH_BS       8'h08
`define ACLP_CH_LF       8'h0A
`define ACLP_CH_CR       8'h0D
`define ACLP_CH_SP       8'h20
`define ACLP_CH_PLUS     8'h2B
`define ACLP_CH_COMMA    8'h2C
`define ACLP_CH_MINUS    8'h2D
`define ACLP_CH_DOT      8'h2E
`define ACLP_CH_ZERO     8'h30
`define ACLP_CH_NINE     8'h39
`define ACLP_CH_COLON    8'h3A
`define ACLP_PULSE_MIN   40'shFFF8000000
`define ACLP_PULSE_MAX   40'sh0007FFFFFF
`define ACLP_ACC_LIMIT   40'h00FFFFFFFF
`define ACLP_LAST_FIELD  3'h3

`endif

// ==== hdl/aclp_pkg.sv ====
// types shared by the axis command line parser
package aclp_pkg;

    typedef enum logic [4:0] {
        CMD_NONE   = 5'h00, CMD_HOME   = 5'h01, CMD_REL    = 5'h02, CMD_ABS    = 5'h03,
        CMD_OVR    = 5'h04, CMD_ARC    = 5'h05, CMD_LIN    = 5'h06, CMD_JOG    = 5'h07,
        CMD_STOP   = 5'h08, CMD_ORIGIN = 5'h09, CMD_SPEED  = 5'h0A, CMD_HSPEED = 5'h0B,
        CMD_FREE   = 5'h0C, CMD_STAT   = 5'h0D, CMD_BUSYQ  = 5'h0E, CMD_INFO   = 5'h0F,
        CMD_OUT    = 5'h10, CMD_IN     = 5'h11, CMD_ALMRST = 5'h12, CMD_PROG   = 5'h13
    } aclp_cmd_e;

    typedef enum logic [1:0] {
        RPL_ACCEPT = 2'h0,
        RPL_REFUSE = 2'h1,
        RPL_STATUS = 2'h2,
        RPL_BUSY   = 2'h3
    } aclp_reply_e;

    typedef logic [3:0][39:0] aclp_vals_t;

    typedef struct packed {
        aclp_reply_e kind;
        aclp_cmd_e   cmd;
        logic        busy_flag;
        logic [3:0]  busy_axes;
    } aclp_reply_s;

    typedef struct packed {
        aclp_cmd_e  cmd;
        logic [3:0] mask;
        aclp_vals_t vals;
    } aclp_exec_s;

    // commands that may address a busy axis
    function automatic logic is_exempt(input aclp_cmd_e c);
        return c inside {CMD_STAT, CMD_INFO, CMD_STOP, CMD_BUSYQ, CMD_IN, CMD_OUT};
    endfunction : is_exempt

    // commands that start motion on acceptance
    function automatic logic is_motion(input aclp_cmd_e c);
        return c inside {CMD_HOME, CMD_REL, CMD_ABS, CMD_ARC, CMD_LIN, CMD_JOG};
    endfunction : is_motion

endpackage : aclp_pkg

// ==== hdl/aclp_line_buf.sv ====
// line assembly buffer with backspace editing
`timescale 1ns/1ns
`include "aclp_map.svh"
module aclp_line_buf (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    // edit controls
    input  wire logic       push_in,
    input  wire logic [7:0] data_in,
    input  wire logic       bs_in,
    input  wire logic       clear_in,
    // read side
    input  wire logic [5:0] rd_idx_in,
    output logic      [7:0] rd_data_out,
    output logic      [7:0] first_out,
    output logic      [7:0] last_out,
    output logic      [5:0] len_out,
    output logic            ovf_out
);
    logic [7:0] mem_q [0:31];
    logic [7:0] mem_d [0:31];
    logic [5:0] len_q, len_d;
    logic       ovf_q, ovf_d;

    // next line contents
    always_comb begin
        mem_d = mem_q;
        len_d = len_q;
        ovf_d = ovf_q;
        if (clear_in) begin
            len_d = 6'h00;
            ovf_d = 1'b0;
        end else if (bs_in) begin
            if (len_q != 6'h00) begin
                len_d = len_q - 6'h01;
            end
        end else if (push_in) begin
            if (len_q < `ACLP_BUF_DEPTH) begin
                mem_d[len_q[4:0]] = data_in;
                len_d = len_q + 6'h01;
            end else begin
                ovf_d = 1'b1; // long line, refused later
            end
        end
    end

    // storage registers
    always_ff @(posedge mclk_in) begin
        mem_q <= mem_d;
        if (!rst_n_in) begin
            len_q <= 6'h00;
            ovf_q <= 1'b0;
        end else begin
            len_q <= len_d;
            ovf_q <= ovf_d;
        end
    end

    // read ports
    assign rd_data_out = mem_q[rd_idx_in[4:0]];
    assign first_out   = mem_q[0];
    assign last_out    = (len_q == 6'h00) ? 8'h00 : mem_q[5'(len_q - 6'h01)];
    assign len_out     = len_q;
    assign ovf_out     = ovf_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_bs_drop;
        (bs_in && !clear_in && len_q != 6'h00) |=> (len_q == $past(len_q) - 6'h01);
    endproperty
    a_bs_drop: assert property (p_bs_drop) else $error("backspace did not drop a char");

endmodule : aclp_line_buf

// ==== hdl/aclp_parser.sv ====
// axis command line parser top
`timescale 1ns/1ns
`include "aclp_map.svh"
module aclp_parser (
    // clock and reset
    input  wire logic                mclk_in,
    input  wire logic                rst_n_in,
    // character stream from the link receiver, same clock
    input  wire logic                rx_valid_in,
    input  wire logic [7:0]          rx_data_in,
    output logic                     rx_ready_out,
    // axis state from the motion engine, same clock
    input  wire logic [3:0]          axis_busy_in,
    input  wire aclp_pkg::aclp_vals_t pos_in,
    // answers and command hand-off
    output logic                     reply_valid_out,
    output aclp_pkg::aclp_reply_s    reply_out,
    output logic                     exec_valid_out,
    output aclp_pkg::aclp_exec_s     exec_out,
    output logic                     motion_start_out
);
    typedef enum logic [2:0] {
        S_COLLECT = 3'h0,
        S_CODE    = 3'h1,
        S_COLON   = 3'h2,
        S_FIELD   = 3'h3,
        S_CHECK   = 3'h4
    } aclp_state_e;

    aclp_state_e           st_q, st_d;
    logic [5:0]            idx_q, idx_d;
    aclp_pkg::aclp_cmd_e   cmd_q, cmd_d;
    logic                  err_q, err_d;
    logic [2:0]            fld_q, fld_d;
    logic                  neg_q, neg_d, sgn_q, sgn_d, dig_q, dig_d;
    aclp_pkg::aclp_vals_t  acc_q, acc_d;
    logic [3:0]            given_q, given_d;
    logic                  rpl_v_d, ex_v_d, mot_d;
    aclp_pkg::aclp_reply_s rpl_d;
    aclp_pkg::aclp_exec_s  ex_d;
    logic                  is_term, is_bs, lb_push, lb_clear, close, busy_hit, bad;
    logic [7:0]            ch, lb_first, lb_last;
    logic [5:0]            lb_len;
    logic                  lb_ovf;
    logic [3:0]            rel_bad, abs_bad, home_bad, home_go;
    logic [39:0]           cur;

    // letter to command, either case accepted
    function automatic aclp_pkg::aclp_cmd_e decode(input logic [7:0] c);
        logic [7:0] u;
        u = (c >= 8'h61 && c <= 8'h7A) ? (c & 8'hDF) : c;
        case (u)
            8'h48:   return aclp_pkg::CMD_HOME;
            8'h4D:   return aclp_pkg::CMD_REL;
            8'h41:   return aclp_pkg::CMD_ABS;
            8'h59:   return aclp_pkg::CMD_OVR;
            8'h45:   return aclp_pkg::CMD_ARC;
            8'h4B:   return aclp_pkg::CMD_LIN;
            8'h4A:   return aclp_pkg::CMD_JOG;
            8'h4C:   return aclp_pkg::CMD_STOP;
            8'h52:   return aclp_pkg::CMD_ORIGIN;
            8'h44:   return aclp_pkg::CMD_SPEED;
            8'h42:   return aclp_pkg::CMD_HSPEED;
            8'h43:   return aclp_pkg::CMD_FREE;
            8'h51:   return aclp_pkg::CMD_STAT;
            8'h21:   return aclp_pkg::CMD_BUSYQ;
            8'h3F:   return aclp_pkg::CMD_INFO;
            8'h4F:   return aclp_pkg::CMD_OUT;
            8'h49:   return aclp_pkg::CMD_IN;
            8'h55:   return aclp_pkg::CMD_ALMRST;
            8'h50:   return aclp_pkg::CMD_PROG;
            default: return aclp_pkg::CMD_NONE;
        endcase
    endfunction : decode

    // receive side controls
    assign rx_ready_out = (st_q == S_COLLECT);
    assign is_term      = (rx_data_in == `ACLP_CH_CR) || (rx_data_in == `ACLP_CH_LF);
    assign is_bs        = (rx_data_in == `ACLP_CH_BS);
    assign lb_push      = rx_valid_in && rx_ready_out && !is_term && !is_bs;
    assign lb_clear     = (st_q == S_CHECK);
    assign cur          = acc_q[fld_q[1:0]];

    aclp_line_buf u_buf (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .push_in     (lb_push),
        .data_in     (rx_data_in),
        .bs_in       (rx_valid_in && rx_ready_out && is_bs),
        .clear_in    (lb_clear),
        .rd_idx_in   (idx_q),
        .rd_data_out (ch),
        .first_out   (lb_first),
        .last_out    (lb_last),
        .len_out     (lb_len),
        .ovf_out     (lb_ovf)
    );

    // per-axis value checks
    for (genvar a = 0; a < 4; a++) begin : g_axis
        logic signed [39:0] v, d;
        assign v           = $signed(acc_q[a]);
        assign d           = v - $signed(pos_in[a]);
        assign rel_bad[a]  = given_q[a] && (v < `ACLP_PULSE_MIN || v > `ACLP_PULSE_MAX);
        assign abs_bad[a]  = given_q[a] && (d < `ACLP_PULSE_MIN || d > `ACLP_PULSE_MAX);
        assign home_bad[a] = given_q[a] && (v != 40'sh0000000000) && (v != 40'sh0000000001);
        assign home_go[a]  = given_q[a] && (v == 40'sh0000000001);
    end

    assign busy_hit = !aclp_pkg::is_exempt(cmd_q) && |(given_q & axis_busy_in);
    assign bad      = err_q || busy_hit
                   || (cmd_q == aclp_pkg::CMD_REL  && |rel_bad)
                   || (cmd_q == aclp_pkg::CMD_ABS  && |abs_bad)
                   || (cmd_q == aclp_pkg::CMD_HOME && |home_bad);

    // parser next state
    always_comb begin
        st_d = st_q; idx_d = idx_q; cmd_d = cmd_q; err_d = err_q; fld_d = fld_q;
        neg_d = neg_q; sgn_d = sgn_q; dig_d = dig_q; acc_d = acc_q; given_d = given_q;
        rpl_v_d = 1'b0; rpl_d = reply_out; ex_v_d = 1'b0; ex_d = exec_out; mot_d = 1'b0;
        close = 1'b0;
        case (st_q)
            S_COLLECT: begin
                if (rx_valid_in && is_term && lb_len != 6'h00) begin
                    st_d    = S_CODE;
                    idx_d   = 6'h00;
                    err_d   = lb_ovf || lb_first == `ACLP_CH_SP || lb_last == `ACLP_CH_SP;
                    fld_d   = 3'h0;
                    neg_d   = 1'b0;
                    sgn_d   = 1'b0;
                    dig_d   = 1'b0;
                    acc_d   = '0;
                    given_d = 4'h0;
                end
            end
            S_CODE: begin
                cmd_d = decode(ch);
                if (decode(ch) == aclp_pkg::CMD_NONE) err_d = 1'b1;
                idx_d = 6'h01;
                st_d  = (lb_len == 6'h01) ? S_CHECK : S_COLON;
            end
            S_COLON: begin
                if (ch != `ACLP_CH_COLON) err_d = 1'b1;
                idx_d = 6'h02;
                st_d  = S_FIELD;
            end
            S_FIELD: begin
                if (idx_q == lb_len) begin
                    close = 1'b1;
                    st_d  = S_CHECK;
                end else begin
                    idx_d = idx_q + 6'h01;
                    if (ch >= `ACLP_CH_ZERO && ch <= `ACLP_CH_NINE) begin
                        dig_d = 1'b1;
                        if (cur > `ACLP_ACC_LIMIT) err_d = 1'b1;
                        else acc_d[fld_q[1:0]] = (cur << 3) + (cur << 1)
                                               + {36'h0, ch[3:0]};
                    end else if (ch == `ACLP_CH_PLUS || ch == `ACLP_CH_MINUS) begin
                        if (sgn_q || dig_q) err_d = 1'b1;
                        sgn_d = 1'b1;
                        neg_d = (ch == `ACLP_CH_MINUS);
                    end else if (ch == `ACLP_CH_COMMA) begin
                        close = 1'b1;
                        if (fld_q >= `ACLP_LAST_FIELD) err_d = 1'b1;
                    end else begin
                        err_d = 1'b1;
                    end
                end
                if (close) begin
                    if (sgn_q && !dig_q) err_d = 1'b1;
                    given_d[fld_q[1:0]] = dig_q;
                    acc_d[fld_q[1:0]]   = neg_q ? (40'h0 - cur) : cur;
                    fld_d = fld_q + 3'h1;
                    neg_d = 1'b0;
                    sgn_d = 1'b0;
                    dig_d = 1'b0;
                end
            end
            S_CHECK: begin
                st_d              = S_COLLECT;
                rpl_v_d           = 1'b1;
                rpl_d.cmd         = cmd_q;
                rpl_d.busy_flag   = |axis_busy_in;
                rpl_d.busy_axes   = axis_busy_in;
                if (bad)
                    rpl_d.kind = aclp_pkg::RPL_REFUSE;
                else if (cmd_q inside {aclp_pkg::CMD_STAT, aclp_pkg::CMD_INFO, aclp_pkg::CMD_IN})
                    rpl_d.kind = aclp_pkg::RPL_STATUS;
                else if (cmd_q == aclp_pkg::CMD_BUSYQ)
                    rpl_d.kind = aclp_pkg::RPL_BUSY;
                else begin
                    rpl_d.kind = aclp_pkg::RPL_ACCEPT;
                    ex_v_d     = 1'b1;
                    ex_d.cmd   = cmd_q;
                    ex_d.mask  = (cmd_q == aclp_pkg::CMD_HOME) ? home_go : given_q;
                    ex_d.vals  = acc_q;
                    mot_d      = aclp_pkg::is_motion(cmd_q);
                end
            end
            default: st_d = S_COLLECT;
        endcase
    end

    // parser registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_q <= S_COLLECT; idx_q <= 6'h00; cmd_q <= aclp_pkg::CMD_NONE; err_q <= 1'b0;
            fld_q <= 3'h0; neg_q <= 1'b0; sgn_q <= 1'b0; dig_q <= 1'b0;
            acc_q <= '0; given_q <= 4'h0;
            reply_valid_out <= 1'b0; reply_out <= '0;
            exec_valid_out <= 1'b0; exec_out <= '0; motion_start_out <= 1'b0;
        end else begin
            st_q <= st_d; idx_q <= idx_d; cmd_q <= cmd_d; err_q <= err_d;
            fld_q <= fld_d; neg_q <= neg_d; sgn_q <= sgn_d; dig_q <= dig_d;
            acc_q <= acc_d; given_q <= given_d;
            reply_valid_out <= rpl_v_d; reply_out <= rpl_d;
            exec_valid_out <= ex_v_d; exec_out <= ex_d; motion_start_out <= mot_d;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_refused;
        reply_valid_out && reply_out.kind == aclp_pkg::RPL_REFUSE && !exec_valid_out;
    endsequence

    property p_term_parse;
        (st_q == S_COLLECT && rx_valid_in && is_term && lb_len != 6'h00) |=> st_q == S_CODE;
    endproperty
    a_term_parse: assert property (p_term_parse) else $error("line not parsed");

    property p_reply_after_check;
        reply_valid_out |-> $past(st_q) == S_CHECK;
    endproperty
    a_reply_after_check: assert property (p_reply_after_check) else $error("stray reply");

    property p_busy_refuse;
        (st_q == S_CHECK && busy_hit) |=> s_refused;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("busy axis not refused");

    property p_dot_refuse;
        (st_q == S_FIELD && idx_q != lb_len && ch == `ACLP_CH_DOT) |-> ##[1:40] s_refused;
    endproperty
    a_dot_refuse: assert property (p_dot_refuse) else $error("fraction accepted");

    property p_space_refuse;
        (st_q == S_CODE && err_q && lb_first == `ACLP_CH_SP) |-> ##[1:40] s_refused;
    endproperty
    a_space_refuse: assert property (p_space_refuse) else $error("space line accepted");

    property p_range_refuse;
        (st_q == S_CHECK && cmd_q == aclp_pkg::CMD_REL && |rel_bad) |=> s_refused;
    endproperty
    a_range_refuse: assert property (p_range_refuse) else $error("range not refused");

    property p_motion_start;
        motion_start_out |-> exec_valid_out && aclp_pkg::is_motion(exec_out.cmd)
                             && reply_out.kind == aclp_pkg::RPL_ACCEPT;
    endproperty
    a_motion_start: assert property (p_motion_start) else $error("bad motion start");

    property p_busy_query;
        (reply_valid_out && reply_out.kind == aclp_pkg::RPL_BUSY)
            |-> reply_out.busy_flag == $past(|axis_busy_in);
    endproperty
    a_busy_query: assert property (p_busy_query) else $error("busy query wrong");

    property p_home_mask;
        (exec_valid_out && exec_out.cmd == aclp_pkg::CMD_HOME) |-> (exec_out.mask & ~$past(given_q)) == 4'h0;
    endproperty
    a_home_mask: assert property (p_home_mask) else $error("home on idle axis");

endmodule : aclp_parser

// ==== testbench/aclp_host_model.sv ====
// host side model that types command lines into the parser one character at a time
`timescale 1ns/1ns
module aclp_host_model (
    // clock
    input  wire logic       mclk_in,
    // character stream toward the parser
    output logic            rx_valid_out,
    output logic      [7:0] rx_data_out,
    input  wire logic       rx_ready_in
);
    logic [7:0] last_q;

    // idle line state: no offer, data shows the inverse of the last character
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out  = 8'hA5;
        last_q       = 8'h5A;
    end

    // offer one character and hold it until the edge that takes it
    task automatic put_char(input logic [7:0] c);
        logic rdy;
        repeat ($urandom_range(2)) begin
            @(posedge mclk_in);
            #1;
            rx_valid_out = 1'b0;
            rx_data_out  = ~last_q;
        end
        @(posedge mclk_in);
        #1;
        rx_valid_out = 1'b1;
        rx_data_out  = c;
        // ready only moves on an edge, so its value after the edge is what the next edge sees
        do begin
            rdy = rx_ready_in;
            @(posedge mclk_in);
        end while (rdy !== 1'b1);
        last_q = c;
        #1;
        rx_valid_out = 1'b0;
        rx_data_out  = ~c;
    endtask : put_char

    // send a whole line, commas as given, then a cr or lf terminator
    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++) begin
            put_char(s[i]);
        end
        put_char($urandom_range(1) ? 8'h0D : 8'h0A);
    endtask : send_line
endmodule : aclp_host_model

// ==== testbench/axis_command_line_parser_tb.sv ====
// self-checking bench for the axis command line parser
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((ex) !== (got)) begin bad_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module axis_command_line_parser_tb;
    typedef struct {
        aclp_pkg::aclp_reply_e kind;
        aclp_pkg::aclp_cmd_e   cmd;
        logic                  mo;
        logic                  bf;
        logic [3:0]            mask;
        aclp_pkg::aclp_vals_t  vals;
    } aclp_note_s;

    localparam aclp_pkg::aclp_reply_e ACC = aclp_pkg::RPL_ACCEPT;
    localparam aclp_pkg::aclp_reply_e REF = aclp_pkg::RPL_REFUSE;
    localparam aclp_pkg::aclp_reply_e STA = aclp_pkg::RPL_STATUS;
    localparam aclp_pkg::aclp_reply_e BSY = aclp_pkg::RPL_BUSY;

    logic                  mclk_in;
    logic                  rst_n_in;
    logic                  rx_valid_in;
    logic [7:0]            rx_data_in;
    logic                  rx_ready_out;
    logic [3:0]            axis_busy_in;
    aclp_pkg::aclp_vals_t  pos_in;
    logic                  reply_valid_out;
    aclp_pkg::aclp_reply_s reply_out;
    logic                  exec_valid_out;
    aclp_pkg::aclp_exec_s  exec_out;
    logic                  motion_start_out;
    aclp_note_s            q[$];
    aclp_note_s            n;
    int                    bad_count;
    int                    compares;
    int                    cycles;
    string                 s;
    logic signed [39:0]    v;

    aclp_parser i_dut (
        .mclk_in          (mclk_in),
        .rst_n_in         (rst_n_in),
        .rx_valid_in      (rx_valid_in),
        .rx_data_in       (rx_data_in),
        .rx_ready_out     (rx_ready_out),
        .axis_busy_in     (axis_busy_in),
        .pos_in           (pos_in),
        .reply_valid_out  (reply_valid_out),
        .reply_out        (reply_out),
        .exec_valid_out   (exec_valid_out),
        .exec_out         (exec_out),
        .motion_start_out (motion_start_out)
    );

    aclp_host_model i_host (
        .mclk_in      (mclk_in),
        .rx_valid_out (rx_valid_in),
        .rx_data_out  (rx_data_in),
        .rx_ready_in  (rx_ready_out)
    );

    // 25 mhz clock
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    function automatic aclp_pkg::aclp_vals_t mk(input logic signed [39:0] a, b, c, d);
        mk = {d, c, b, a};
    endfunction : mk

    // expected command for the first character of a line, either letter case
    function automatic aclp_pkg::aclp_cmd_e exp_cmd(input logic [7:0] c);
        case (c | 8'h20)
            8'h68:   exp_cmd = aclp_pkg::CMD_HOME;
            8'h6D:   exp_cmd = aclp_pkg::CMD_REL;
            8'h61:   exp_cmd = aclp_pkg::CMD_ABS;
            8'h6A:   exp_cmd = aclp_pkg::CMD_JOG;
            8'h6B:   exp_cmd = aclp_pkg::CMD_LIN;
            8'h6C:   exp_cmd = aclp_pkg::CMD_STOP;
            8'h6F:   exp_cmd = aclp_pkg::CMD_OUT;
            8'h71:   exp_cmd = aclp_pkg::CMD_STAT;
            8'h69:   exp_cmd = aclp_pkg::CMD_IN;
            8'h21:   exp_cmd = aclp_pkg::CMD_BUSYQ;
            8'h3F:   exp_cmd = aclp_pkg::CMD_INFO;
            default: exp_cmd = aclp_pkg::CMD_NONE;
        endcase
    endfunction : exp_cmd

    // final report and end of run
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // note the expected answer, type the line, wait for the answer to be consumed
    task automatic go(input string ln, input aclp_pkg::aclp_reply_e k, input logic [3:0] m,
                      input logic mo, input logic bf, input aclp_pkg::aclp_vals_t vals);
        aclp_note_s e;
        int w;
        e.kind = k;
        e.cmd  = exp_cmd(ln[0]);
        e.mo   = mo;
        e.bf   = bf;
        e.mask = m;
        e.vals = vals;
        q.push_back(e);
        i_host.send_line(ln);
        w = 0;
        while (q.size() != 0 && w < 200) begin
            @(posedge mclk_in);
            w++;
        end
        if (q.size() != 0) begin
            bad_count++;
            $display("[FAIL] reply to %s expected 1 seen 0", ln);
            q.delete();
        end
    endtask : go

    // watcher: each answer takes the oldest note and is compared against it
    always @(posedge mclk_in) begin
        if (rst_n_in === 1'b1 && reply_valid_out === 1'b1) begin
            if (q.size() == 0) begin
                `CHK("unexpected reply", 1'b0, 1'b1)
            end else begin
                n = q.pop_front();
                `CHK("reply kind", n.kind, reply_out.kind)
                `CHK("reply cmd", n.cmd, reply_out.cmd)
                `CHK("busy axes", axis_busy_in, reply_out.busy_axes)
                `CHK("exec", (n.kind == ACC), exec_valid_out)
                `CHK("motion", n.mo, motion_start_out)
                if (n.kind == BSY) `CHK("busy flag", n.bf, reply_out.busy_flag)
                if (n.kind == ACC) begin
                    `CHK("mask", n.mask, exec_out.mask)
                    `CHK("exec cmd", n.cmd, exec_out.cmd)
                    for (int i = 0; i < 4; i++) begin
                        if (n.mask[i]) `CHK("vals", n.vals[i], exec_out.vals[i])
                    end
                end
            end
        end else if (rst_n_in === 1'b1 && exec_valid_out === 1'b1) begin
            `CHK("exec without reply", 1'b0, 1'b1)
        end
    end

    // hang guard
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        bad_count    = 0;
        compares     = 0;
        cycles       = 0;
        rst_n_in     = 1'b0;
        axis_busy_in = 4'h0;
        pos_in       = mk(40'sh64, 0, 0, 0);
        void'($urandom(19));
        repeat (5) @(posedge mclk_in);
        #1;
        rst_n_in = 1'b1;
        go("M:5", ACC, 4'h1, 1, 0, mk(5, 0, 0, 0));
        go("m:+7", ACC, 4'h1, 1, 0, mk(7, 0, 0, 0));
        go("M:,,,9", ACC, 4'h8, 1, 0, mk(0, 0, 0, 9));
        go("a:,-3,12", ACC, 4'h6, 1, 0, mk(0, -3, 12, 0));
        s = "M:3x4";
        s.putc(3, 8'h08);
        go(s, ACC, 4'h1, 1, 0, mk(4, 0, 0, 0));
        go("M:1.5", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go(" M:5", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("M:5 ", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("G", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("g:1", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("M:1,2,3,4,5", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        s = "M:";
        repeat (16) s = {s, "1,"};
        go(s, REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("M:134217727", ACC, 4'h1, 1, 0, mk(134217727, 0, 0, 0));
        go("M:134217728", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("M:-134217728", ACC, 4'h1, 1, 0, mk(-134217728, 0, 0, 0));
        go("M:-134217729", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("A:134217827", ACC, 4'h1, 1, 0, mk(134217827, 0, 0, 0));
        go("A:134217828", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("H:1,0,,1", ACC, 4'h9, 1, 0, mk(1, 0, 0, 1));
        go("H:2", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("J:1", ACC, 4'h1, 1, 0, mk(1, 0, 0, 0));
        go("k:1,1", ACC, 4'h3, 1, 0, mk(1, 1, 0, 0));
        repeat (4) begin
            v = $urandom_range(134217727);
            if ($urandom_range(1)) v = -v;
            go($sformatf("M:,,%0d", v), ACC, 4'h4, 1, 0, mk(0, 0, v, 0));
        end
        i_host.send_line("");
        go("Q", STA, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("!", BSY, 4'h0, 0, 0, mk(0, 0, 0, 0));
        @(posedge mclk_in);
        #1;
        axis_busy_in = 4'h1;
        go("M:5", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("H:1", REF, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("M:,5", ACC, 4'h2, 1, 0, mk(0, 5, 0, 0));
        go("Q", STA, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("?", STA, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("i", STA, 4'h0, 0, 0, mk(0, 0, 0, 0));
        go("!", BSY, 4'h0, 0, 1, mk(0, 0, 0, 0));
        go("L:1", ACC, 4'h1, 0, 0, mk(1, 0, 0, 0));
        go("O:1", ACC, 4'h1, 0, 0, mk(1, 0, 0, 0));
        @(posedge mclk_in);
        #1;
        axis_busy_in = 4'h0;
        go("!", BSY, 4'h0, 0, 0, mk(0, 0, 0, 0));
        repeat (10) @(posedge mclk_in);
        give_verdict();
    end
endmodule : axis_command_line_parser_tb
